/* far_end.sv */
/* far side of the unit: register file, word memory with a prompt
   or slow ack, overflow flag and program counter.
   assumes the unit holds mem_req until ack and pulses its writes. */
`timescale 1ns/1ps
module far_end (
    input  wire logic        sys_clk,
    input  wire logic        slow,
    input  wire logic [3:0]  rf_raddr_a,
    output logic [15:0]      rf_rdata_a,
    input  wire logic [3:0]  rf_raddr_b,
    output logic [15:0]      rf_rdata_b,
    input  wire logic        rf_we,
    input  wire logic [3:0]  rf_waddr,
    input  wire logic [15:0] rf_wdata,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic [15:0]      mem_rdata,
    output logic             mem_ack,
    input  wire logic        ovf_we,
    input  wire logic        ovf_value,
    input  wire logic        pc_load,
    input  wire logic [15:0] pc_target,
    input  wire logic        pc_step,
    input  wire logic [1:0]  pc_step_amount
);
    // ======
    // storage
    logic [15:0] regs [16];
    logic [15:0] mem [256];
    logic [1:0]  wait_q;
    logic        ovf_q;
    logic [15:0] pc_q;
    assign rf_rdata_a = regs[rf_raddr_a];
    assign rf_rdata_b = regs[rf_raddr_b];
    // data line is garbage outside the ack cycle
    assign mem_rdata = mem_ack ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];
    always @(posedge sys_clk) begin
        if (rf_we)
            regs[rf_waddr] <= rf_wdata;
        if (ovf_we)
            ovf_q <= ovf_value;
        if (pc_load)
            pc_q <= pc_target;
        else if (pc_step)
            pc_q <= pc_q + 16'(pc_step_amount);
        mem_ack <= 1'b0;
        wait_q <= 2'h0;
        if (mem_req && !mem_ack && wait_q == (slow ? 2'h3 : 2'h0)) begin
            mem_ack <= 1'b1;
            if (mem_we)
                mem[mem_addr[7:0]] <= mem_wdata;
        end else if (mem_req && !mem_ack)
            wait_q <= wait_q + 2'h1;
    end
endmodule

/* shift_and_bit_literal_unit.sv */
/*
 * Shift and bit-literal execution unit of a 16-bit word processor:
 * stepwise shifts on one register or an even-odd pair, one-bit rotate,
 * one-hot register load and add-bit-in-memory with optional branch.
 * Assumes a register file with two combinational read ports and one
 * write port, and a memory port that answers each request with ack.
 */
// Behaviour
// - pair arith left: keep even sign, zeros into odd, odd msb to even.
// - single and pair arith left shifts also update overflow.
// - pair arith right: keep sign, even lsb into odd msb, odd lsb lost.
// - single arith left: keep sign, drop bit 1, zeros at bottom.
// - single arith right: keep sign, drop bits leaving the bottom.
// - pair logic left: zeros into odd, odd top into even, even top lost.
// - pair logic right: zeros into even, even low into odd, odd low lost.
// - single logic left: zero fill low end, top bits lost.
// - single logic right: zero fill high end, low bits lost.
// - rotate writes source left by one, msb to bit 15; no count.
// - other shifts move zero to 15 positions by the count field.
// - bit field n gives a one-hot literal of weight two to 15-n.
// - literal add carries leftward through the sign bit.
// - one-hot load writes one at n and zeros elsewhere.
// - jumping one-hot load always loads pc from word two.
// - add-bit-in-memory writes back and flags signed overflow.
// - long branch form: nonzero jumps to word three, zero goes on.
// - displaced forms address register one plus displacement.
// - displaced branch: nonzero loads pc from word two, zero adds 2.
// - indexed form addresses the named index register contents.
// - shift count is instruction bits 12-15, unsigned.
// - pair arith shifts treat even as high half, odd as low.
`timescale 1ns/1ps
`include "shift_bit_cfg.svh"

module shift_and_bit_literal_unit #(
    parameter int DATA_W = `SBU_WORD_W
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 start,
    input  wire shift_bit_pkg::op_t   op,
    input  wire logic [15:0]          instr_word,
    input  wire logic [15:0]          word_two,
    input  wire logic [15:0]          word_three,
    output logic                      busy,
    output logic                      done,
    output logic [3:0]                rf_raddr_a,
    input  wire logic [15:0]          rf_rdata_a,
    output logic [3:0]                rf_raddr_b,
    input  wire logic [15:0]          rf_rdata_b,
    output logic                      rf_we,
    output logic [3:0]                rf_waddr,
    output logic [15:0]               rf_wdata,
    output logic                      mem_req,
    output logic                      mem_we,
    output logic [15:0]               mem_addr,
    output logic [15:0]               mem_wdata,
    input  wire logic [15:0]          mem_rdata,
    input  wire logic                 mem_ack,
    output logic                      ovf_we,
    output logic                      ovf_value,
    output logic                      pc_load,
    output logic [15:0]               pc_target,
    output logic                      pc_step,
    output logic [1:0]                pc_step_amount
);

    // =================================================================
    // elaboration check
    if (DATA_W != 16) begin : g_width_check
        $error("shift_and_bit_literal_unit serves 16-bit words only");
    end

    // =================================================================
    // helpers
    function automatic logic [15:0] one_hot(input logic [3:0] n);
        return `SBU_LIT_TOP >> n;
    endfunction

    function automatic logic is_pair(input shift_bit_pkg::op_t o);
        return o == shift_bit_pkg::OP_SHIFT_LEFT_ARITH_PAIR ||
               o == shift_bit_pkg::OP_SHIFT_RIGHT_ARITH_PAIR ||
               o == shift_bit_pkg::OP_SHIFT_LEFT_LOGIC_PAIR ||
               o == shift_bit_pkg::OP_SHIFT_RIGHT_LOGIC_PAIR;
    endfunction

    function automatic logic is_left_arith(input shift_bit_pkg::op_t o);
        return o == shift_bit_pkg::OP_SHIFT_LEFT_ARITH_PAIR ||
               o == shift_bit_pkg::OP_SHIFT_LEFT_ARITH_ONE;
    endfunction

    function automatic logic is_shift(input shift_bit_pkg::op_t o);
        return o >= shift_bit_pkg::OP_SHIFT_LEFT_ARITH_PAIR &&
               o <= shift_bit_pkg::OP_SHIFT_RIGHT_LOGIC_ONE;
    endfunction

    function automatic logic is_mem(input shift_bit_pkg::op_t o);
        return o >= shift_bit_pkg::OP_ADD_BIT_MEM_LONG;
    endfunction

    // one shift step: {discarded bit differs from sign, hi, lo}
    function automatic logic [32:0] shift_step(
        input shift_bit_pkg::op_t o,
        input logic [15:0]        hi,
        input logic [15:0]        lo
    );
        case (o)
            shift_bit_pkg::OP_SHIFT_LEFT_ARITH_PAIR:
                return {hi[14] ^ hi[15], hi[15], hi[13:0], lo[15],
                        lo[14:0], 1'b0};
            shift_bit_pkg::OP_SHIFT_LEFT_ARITH_ONE:
                return {hi[14] ^ hi[15], hi[15], hi[13:0], 1'b0, lo};
            shift_bit_pkg::OP_SHIFT_RIGHT_ARITH_PAIR:
                return {1'b0, hi[15], hi[15:1], hi[0], lo[15:1]};
            shift_bit_pkg::OP_SHIFT_RIGHT_ARITH_ONE:
                return {1'b0, hi[15], hi[15:1], lo};
            shift_bit_pkg::OP_SHIFT_LEFT_LOGIC_PAIR:
                return {1'b0, hi[14:0], lo[15], lo[14:0], 1'b0};
            shift_bit_pkg::OP_SHIFT_LEFT_LOGIC_ONE:
                return {1'b0, hi[14:0], 1'b0, lo};
            shift_bit_pkg::OP_SHIFT_RIGHT_LOGIC_PAIR:
                return {1'b0, 1'b0, hi[15:1], hi[0], lo[15:1]};
            shift_bit_pkg::OP_SHIFT_RIGHT_LOGIC_ONE:
                return {1'b0, 1'b0, hi[15:1], lo};
            default:
                return {1'b0, hi, lo};
        endcase
    endfunction

    // =================================================================
    // instruction fields
    logic [3:0]  sh_reg;
    logic [3:0]  sh_cnt;
    logic [3:0]  rot_src;
    logic [3:0]  bit_n;
    logic [3:0]  bit_reg;
    logic [15:0] disp;

    assign sh_reg  = instr_word[`SBU_SH_REG_LSB +: `SBU_FIELD_W];
    assign sh_cnt  = instr_word[`SBU_SH_CNT_LSB +: `SBU_FIELD_W];
    assign rot_src = instr_word[`SBU_ROT_SRC_LSB +: `SBU_FIELD_W];
    assign bit_n   = instr_word[`SBU_BIT_N_LSB +: `SBU_FIELD_W];
    assign bit_reg = instr_word[`SBU_BIT_REG_LSB +: `SBU_FIELD_W];
    assign disp    = {12'h000, instr_word[`SBU_DISP_LSB +: `SBU_FIELD_W]};

    // =================================================================
    // register file reads, taken in the start cycle
    always_comb begin
        case (op)
            shift_bit_pkg::OP_ROTATE_LEFT_ONE:
                rf_raddr_a = rot_src;
            shift_bit_pkg::OP_ADD_BIT_MEM_DISPLACED,
            shift_bit_pkg::OP_ADD_BIT_MEM_DISPLACED_BRANCH:
                rf_raddr_a = `SBU_BASE_REG;
            shift_bit_pkg::OP_ADD_BIT_MEM_INDEXED:
                rf_raddr_a = bit_reg;
            default:
                rf_raddr_a = sh_reg;
        endcase
    end
    assign rf_raddr_b = {sh_reg[3:1], 1'b1};

    // =================================================================
    // sequencer state
    shift_bit_pkg::state_t state_q;
    shift_bit_pkg::op_t    op_q;
    logic [3:0]            cnt_q;
    logic [3:0]            dst_q;
    logic [15:0]           hi_q;
    logic [15:0]           lo_q;
    logic                  ovf_q;
    logic                  moved_q;
    logic [15:0]           addr_q;
    logic [15:0]           old_q;
    logic [15:0]           lit_q;
    logic [15:0]           tgt_q;
    logic [32:0]           step;
    logic [15:0]           sum;

    assign step = shift_step(op_q, hi_q, lo_q);
    assign sum  = mem_rdata + lit_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= shift_bit_pkg::ST_IDLE;
        end else begin
            case (state_q)
                shift_bit_pkg::ST_IDLE: begin
                    if (start && is_shift(op)) begin
                        state_q <= (sh_cnt == 4'h0) ?
                                   shift_bit_pkg::ST_DONE :
                                   shift_bit_pkg::ST_SHIFT;
                    end else if (start && is_mem(op)) begin
                        state_q <= shift_bit_pkg::ST_MEM_RD;
                    end else if (start && op != shift_bit_pkg::OP_NONE) begin
                        state_q <= shift_bit_pkg::ST_WR_HI;
                    end
                end
                shift_bit_pkg::ST_SHIFT: begin
                    if (cnt_q == 4'h1) begin
                        state_q <= shift_bit_pkg::ST_WR_HI;
                    end
                end
                shift_bit_pkg::ST_WR_HI: begin
                    state_q <= is_pair(op_q) ? shift_bit_pkg::ST_WR_LO :
                               shift_bit_pkg::ST_DONE;
                end
                shift_bit_pkg::ST_WR_LO: begin
                    state_q <= shift_bit_pkg::ST_DONE;
                end
                shift_bit_pkg::ST_MEM_RD: begin
                    if (mem_ack) begin
                        state_q <= shift_bit_pkg::ST_MEM_WR;
                    end
                end
                shift_bit_pkg::ST_MEM_WR: begin
                    if (mem_ack) begin
                        state_q <= shift_bit_pkg::ST_DONE;
                    end
                end
                default: begin
                    state_q <= shift_bit_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // captured command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op_q  <= shift_bit_pkg::OP_NONE;
            dst_q <= 4'h0;
            lit_q <= `SBU_ZERO_WORD;
            tgt_q <= `SBU_ZERO_WORD;
        end else if (state_q == shift_bit_pkg::ST_IDLE && start) begin
            op_q  <= op;
            dst_q <= (op == shift_bit_pkg::OP_LOAD_ONE_HOT_REG ||
                      op == shift_bit_pkg::OP_LOAD_ONE_HOT_REG_JUMP) ?
                     bit_reg : sh_reg;
            lit_q <= one_hot(bit_n);
            tgt_q <= (op == shift_bit_pkg::OP_ADD_BIT_MEM_LONG_BRANCH) ?
                     word_three : word_two;
        end
    end

    // operand pair and shift counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hi_q  <= `SBU_ZERO_WORD;
            lo_q  <= `SBU_ZERO_WORD;
            cnt_q <= 4'h0;
            ovf_q <= 1'b0;
            moved_q <= 1'b0;
        end else if (state_q == shift_bit_pkg::ST_IDLE && start) begin
            cnt_q <= sh_cnt;
            ovf_q <= 1'b0;
            moved_q <= 1'b0;
            lo_q  <= rf_rdata_b;
            case (op)
                shift_bit_pkg::OP_ROTATE_LEFT_ONE:
                    hi_q <= {rf_rdata_a[14:0], rf_rdata_a[15]};
                shift_bit_pkg::OP_LOAD_ONE_HOT_REG,
                shift_bit_pkg::OP_LOAD_ONE_HOT_REG_JUMP:
                    hi_q <= one_hot(bit_n);
                default:
                    hi_q <= rf_rdata_a;
            endcase
        end else if (state_q == shift_bit_pkg::ST_SHIFT) begin
            {hi_q, lo_q} <= step[31:0];
            ovf_q        <= ovf_q | step[32];
            cnt_q        <= cnt_q - 4'h1;
            moved_q      <= 1'b1;
        end
    end

    // memory address and data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_q <= `SBU_ZERO_WORD;
            old_q  <= `SBU_ZERO_WORD;
        end else if (state_q == shift_bit_pkg::ST_IDLE && start) begin
            case (op)
                shift_bit_pkg::OP_ADD_BIT_MEM_DISPLACED,
                shift_bit_pkg::OP_ADD_BIT_MEM_DISPLACED_BRANCH:
                    addr_q <= rf_rdata_a + disp;
                shift_bit_pkg::OP_ADD_BIT_MEM_INDEXED:
                    addr_q <= rf_rdata_a;
                default:
                    addr_q <= word_two;
            endcase
        end else if (state_q == shift_bit_pkg::ST_MEM_RD && mem_ack) begin
            old_q <= mem_rdata;
        end
    end

    logic [15:0] result_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_q <= `SBU_ZERO_WORD;
        end else if (state_q == shift_bit_pkg::ST_MEM_RD && mem_ack) begin
            result_q <= sum;
        end
    end

    // =================================================================
    // outputs
    logic fin;
    logic br_taken;
    assign fin      = state_q == shift_bit_pkg::ST_DONE;
    assign br_taken = result_q != `SBU_ZERO_WORD;
    assign busy     = state_q != shift_bit_pkg::ST_IDLE;
    assign done     = fin;

    assign rf_we    = state_q == shift_bit_pkg::ST_WR_HI ||
                      state_q == shift_bit_pkg::ST_WR_LO;
    assign rf_waddr = (state_q == shift_bit_pkg::ST_WR_LO) ?
                      {dst_q[3:1], 1'b1} : dst_q;
    assign rf_wdata = (state_q == shift_bit_pkg::ST_WR_LO) ? lo_q : hi_q;

    assign mem_req   = state_q == shift_bit_pkg::ST_MEM_RD ||
                       state_q == shift_bit_pkg::ST_MEM_WR;
    assign mem_we    = state_q == shift_bit_pkg::ST_MEM_WR;
    assign mem_addr  = addr_q;
    assign mem_wdata = result_q;

    // count zero never shifted, so it leaves the flag alone
    assign ovf_we    = fin && (is_mem(op_q) ||
                               (is_left_arith(op_q) && moved_q));
    assign ovf_value = is_mem(op_q) ?
                       (~old_q[15] & result_q[15]) : ovf_q;

    assign pc_target = tgt_q;
    always_comb begin
        pc_load        = 1'b0;
        pc_step        = 1'b0;
        pc_step_amount = 2'h0;
        if (fin) begin
            case (op_q)
                shift_bit_pkg::OP_LOAD_ONE_HOT_REG_JUMP:
                    pc_load = 1'b1;
                shift_bit_pkg::OP_ADD_BIT_MEM_LONG_BRANCH: begin
                    pc_load        = br_taken;
                    pc_step        = !br_taken;
                    pc_step_amount = br_taken ? 2'h0 : `SBU_STEP_LONG;
                end
                shift_bit_pkg::OP_ADD_BIT_MEM_DISPLACED_BRANCH: begin
                    pc_load        = br_taken;
                    pc_step        = !br_taken;
                    pc_step_amount = br_taken ? 2'h0 : `SBU_STEP_SHORT;
                end
                default: begin
                    pc_load = 1'b0;
                end
            endcase
        end
    end

    // =================================================================
    // checks
    logic [15:0] src_seen_q;
    always_ff @(posedge sys_clk) begin
        src_seen_q <= rf_rdata_a;
    end

    chk_sign_hold_left: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == shift_bit_pkg::ST_SHIFT && is_left_arith(op_q)
        |=> hi_q[15] == $past(hi_q[15]))
        else $error("arith left shift changed the sign bit");

    chk_zero_count: assert property (@(posedge sys_clk) disable iff (rst)
        start && !busy && is_shift(op) && sh_cnt == 4'h0
        |=> done && !ovf_we && !rf_we)
        else $error("zero count touched registers or overflow");

    chk_rotate_word: assert property (@(posedge sys_clk) disable iff (rst)
        start && !busy && op == shift_bit_pkg::OP_ROTATE_LEFT_ONE
        |=> rf_we && rf_wdata == {src_seen_q[14:0], src_seen_q[15]})
        else $error("rotate result wrong");

    chk_one_hot_load: assert property (@(posedge sys_clk) disable iff (rst)
        start && !busy && op == shift_bit_pkg::OP_LOAD_ONE_HOT_REG
        |=> rf_we && $onehot(rf_wdata))
        else $error("one-hot load not one-hot");

    chk_jump_target: assert property (@(posedge sys_clk) disable iff (rst)
        start && !busy && op == shift_bit_pkg::OP_LOAD_ONE_HOT_REG_JUMP
        |=> ##1 pc_load && pc_target == $past(word_two, 2))
        else $error("jumping load did not load pc");

    chk_pair_order: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == shift_bit_pkg::ST_WR_HI && is_pair(op_q)
        |-> !rf_waddr[0] ##1 rf_we && rf_waddr[0] ##1 done)
        else $error("pair write order wrong");

    chk_short_step: assert property (@(posedge sys_clk) disable iff (rst)
        fin && op_q == shift_bit_pkg::OP_ADD_BIT_MEM_DISPLACED_BRANCH
        && result_q == `SBU_ZERO_WORD
        |-> pc_step && pc_step_amount == 2'h2 && !pc_load)
        else $error("zero result did not step pc by two");

    chk_add_overflow: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == shift_bit_pkg::ST_MEM_WR && mem_ack
        |=> ovf_we && ovf_value == (!old_q[15] && result_q[15]))
        else $error("add-bit overflow wrong");

    cov_pair_shift: cover property (@(posedge sys_clk)
        state_q == shift_bit_pkg::ST_WR_LO && cnt_q == 4'h0);
    cov_long_branch: cover property (@(posedge sys_clk)
        pc_load && op_q == shift_bit_pkg::OP_ADD_BIT_MEM_LONG_BRANCH);
    cov_add_ovf: cover property (@(posedge sys_clk) ovf_we && ovf_value);

endmodule

/* shift_and_bit_literal_unit_tb.sv */
/* self-checking bench of the shift and bit-literal unit.
   assumes far_end models register file, memory, flag and pc. */
`timescale 1ns/1ps
module shift_and_bit_literal_unit_tb;
    logic        sys_clk, rst, start, slow, busy, done, rf_we, mem_req;
    logic        mem_we, mem_ack, ovf_we, ovf_value, pc_load, pc_step;
    logic [1:0]  pc_step_amount;
    logic [3:0]  rf_raddr_a, rf_raddr_b, rf_waddr;
    logic [15:0] instr_word, word_two, word_three, rf_rdata_a, rf_rdata_b;
    logic [15:0] rf_wdata, mem_addr, mem_wdata, mem_rdata, pc_target;
    shift_bit_pkg::op_t op;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    shift_and_bit_literal_unit shift_and_bit_literal_unit_i (.*);
    far_end far_end_i (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    // ======
    // shared tasks
    task automatic check_word(string s, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic run(int o, logic [15:0] iw, w2, w3);
        int n;
        @(negedge sys_clk);
        start = 1'b1;
        op = shift_bit_pkg::op_t'(o);
        instr_word = iw;
        word_two = w2;
        word_three = w3;
        @(negedge sys_clk);
        start = 1'b0;
        for (n = 0; n < 100 && done !== 1'b1; n++)
            @(negedge sys_clk);
        check_word("done", 16'h1, {15'h0, done});
        @(negedge sys_clk);
    endtask
    function automatic logic [32:0] shifted(int k, logic [31:0] x, int c);
        logic ov;
        ov = 1'b0;
        for (int i = 0; i < c; i++)
            if (k == 0 && x[30 - i] != x[31])
                ov = 1'b1;
        case (k)
            0: return {ov, x[31], 31'(x << c)};
            1: return {ov, 32'($signed(x) >>> c)};
            2: return {ov, x << c};
            default: return {ov, x >> c};
        endcase
    endfunction
    // ======
    // scenarios
    task automatic test_shifts(logic pair);
        logic [32:0] e;
        logic [15:0] hi;
        int c;
        for (int k = 0; k < 8 * 3; k++) begin
            hi = k[0] ? 16'h4001 : 16'hb5a3;
            c = k[2:1] == 0 ? 0 : (k[2:1] == 1 ? 3 : 15);
            far_end_i.regs[4] = hi;
            far_end_i.regs[5] = 16'h9c31;
            far_end_i.ovf_q = !(k / 6 == 0 && c != 0);
            e = shifted(k / 6, pair ? {hi, 16'h9c31} : {hi, 16'h0}, c);
            run((pair ? 1 : 3) + (k / 12) * 4 + (k / 6) % 2,
                {8'h0, 4'h4, 4'(c)}, 16'h0, 16'h0);
            check_word("high", e[31:16], far_end_i.regs[4]);
            check_word("low", pair ? e[15:0] : 16'h9c31,
                       far_end_i.regs[5]);
            check_word("ovf", {15'h0, e[32] | !(k / 6 == 0 && c != 0)},
                       {15'h0, far_end_i.ovf_q});
        end
        $display("test shifts pair=%0d done", pair);
    endtask
    task automatic test_bits();
        logic [15:0] v;
        for (int n = 0; n < 16; n++) begin
            v = 16'hc001 ^ 16'(n << 4);
            far_end_i.regs[2] = v;
            far_end_i.pc_q = 16'h0100;
            run(9, 16'h0062, 16'h0, 16'h0);
            check_word("rotated", {v[14:0], v[15]}, far_end_i.regs[6]);
            check_word("rotate source", v, far_end_i.regs[2]);
            run(10 + n % 2, {8'h0, 4'(n), 4'h7}, 16'h2a00 + 16'(n), 16'h0);
            check_word("one hot", 16'h8000 >> n, far_end_i.regs[7]);
            check_word("pc", n % 2 ? 16'h2a00 + 16'(n) : 16'h0100,
                       far_end_i.pc_q);
        end
        $display("test rotate and one-hot load done");
    endtask
    task automatic mem_case(int o, logic [3:0] n, f, logic [15:0] w2, w3,
                            logic [7:0] a, logic [15:0] old, pc_exp);
        logic [15:0] sum;
        sum = old + (16'h8000 >> n);
        far_end_i.mem[a] = old;
        far_end_i.pc_q = 16'h0100;
        far_end_i.ovf_q = old[15] || !sum[15];
        slow = o[0];
        run(o, {8'h0, n, f}, w2, w3);
        check_word("mem", sum, far_end_i.mem[a]);
        check_word("ovf", {15'h0, !old[15] && sum[15]},
                   {15'h0, far_end_i.ovf_q});
        check_word("pc", pc_exp, far_end_i.pc_q);
    endtask
    task automatic test_mem();
        far_end_i.regs[1] = 16'h0010;
        far_end_i.regs[9] = 16'h0066;
        mem_case(15, 4'hf, 4'h3, 16'h3000, 0, 8'h13, 16'h7fff, 16'h3000);
        mem_case(15, 4'hf, 4'hf, 16'h3000, 0, 8'h1f, 16'hffff, 16'h0102);
        mem_case(14, 4'h4, 4'h0, 16'h0, 0, 8'h10, 16'h0123, 16'h0100);
        mem_case(12, 4'h0, 4'h0, 16'h0044, 0, 8'h44, 16'h8000, 16'h0100);
        mem_case(13, 4'hf, 4'h0, 16'h0055, 16'h4000, 8'h55, 16'h00ff, 16'h4000);
        mem_case(13, 4'hf, 4'h0, 16'h0056, 16'h4000, 8'h56, 16'hffff, 16'h0103);
        mem_case(16, 4'h1, 4'h9, 16'h0, 0, 8'h66, 16'h3fff, 16'h0100);
        $display("test memory bit adds done");
    endtask
    initial begin
        {rst, start, slow} = 3'h4;
        op = shift_bit_pkg::OP_NONE;
        {instr_word, word_two, word_three} = 48'h0;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        check_word("idle", 16'h0, {14'h0, busy, done});
        test_shifts(1'b0);
        test_shifts(1'b1);
        test_bits();
        test_mem();
        print_verdict();
    end
endmodule

/* shift_bit_cfg.svh */
/*
 * Constants of the shift and bit-literal unit: instruction field
 * positions, register numbers, operand width and program counter steps.
 * Assumes instruction bit 0 is the MSB, so printed bits 12-15 are [3:0].
 */
`ifndef SHIFT_BIT_CFG_SVH
`define SHIFT_BIT_CFG_SVH

// =====================================================================
// operand and field widths
`define SBU_WORD_W       16
`define SBU_FIELD_W      4

// =====================================================================
// field positions inside the first instruction word (lsb numbering)
`define SBU_SH_REG_LSB   4
`define SBU_SH_CNT_LSB   0
`define SBU_ROT_SRC_LSB  0
`define SBU_BIT_N_LSB    4
`define SBU_BIT_REG_LSB  0
`define SBU_DISP_LSB     0

// =====================================================================
// fixed register numbers, literal seed and program counter steps
`define SBU_BASE_REG     4'h1
`define SBU_LIT_TOP      16'h8000
`define SBU_STEP_SHORT   2'h2
`define SBU_STEP_LONG    2'h3
`define SBU_ZERO_WORD    16'h0000

`endif

/* shift_bit_pkg.sv */
/*
 * Types of the shift and bit-literal unit: operation codes from the
 * instruction decoder and the sequencer states.
 * Assumes the decoder maps each opcode onto one op_t value.
 */
package shift_bit_pkg;

    // =================================================================
    // operations
    typedef enum logic [4:0] {
        OP_NONE,
        OP_SHIFT_LEFT_ARITH_PAIR,
        OP_SHIFT_RIGHT_ARITH_PAIR,
        OP_SHIFT_LEFT_ARITH_ONE,
        OP_SHIFT_RIGHT_ARITH_ONE,
        OP_SHIFT_LEFT_LOGIC_PAIR,
        OP_SHIFT_RIGHT_LOGIC_PAIR,
        OP_SHIFT_LEFT_LOGIC_ONE,
        OP_SHIFT_RIGHT_LOGIC_ONE,
        OP_ROTATE_LEFT_ONE,
        OP_LOAD_ONE_HOT_REG,
        OP_LOAD_ONE_HOT_REG_JUMP,
        OP_ADD_BIT_MEM_LONG,
        OP_ADD_BIT_MEM_LONG_BRANCH,
        OP_ADD_BIT_MEM_DISPLACED,
        OP_ADD_BIT_MEM_DISPLACED_BRANCH,
        OP_ADD_BIT_MEM_INDEXED
    } op_t;

    // =================================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_WR_HI,
        ST_WR_LO,
        ST_MEM_RD,
        ST_MEM_WR,
        ST_DONE
    } state_t;

endpackage
